// >>> cid_core.sv
// Instruction decode block with APB register access and a small executor
// What this block does
// - Stack lives in internal data, grows upward; push increments then writes.
// - Stack top pointer resets to 0x07, first push lands at 0x08.
// - Register opcodes pick working register 0-7 of current bank from low bits.
// - Direct operand 0x00-0x7F is data RAM, 0x80-0xFF is special function area.
// - Indirect operand uses working register 0 or 1 as full 8-bit RAM address.
// - 11-bit target replaces low eleven bits of next instruction address.
// - Relative target adds signed 8-bit offset to next instruction address.
// - 16-bit target reaches anywhere in 64 KB program space.
// - Add 24-2F, add-with-carry 34-3F; register 1 cycle, others 2 cycles.
// - Subtract-with-borrow 94-9F; immediate 94; register forms 1 cycle, others 2.
// - AND 52-5F; accumulator to direct 3 cycles; immediate to direct 3 bytes, 4 cycles.
// - OR 42-4F with AND's lengths and cycles; direct destinations 42 and 43.
// - XOR 62-6F; register forms 1 cycle; accumulator to direct 3 cycles.
// - Four accumulator rotates are one byte, one cycle each.
// - Nibble swap, clear and complement of accumulator are one byte, one cycle.
// - Moves into accumulator E5-EF and 74; register 1 cycle, others 2.
// - Moves into working register take 2, 2 and 4 cycles by source.
// - Direct-to-direct move is 3 bytes, 4 cycles, source first; 75 takes 3.
// - Pointer load from immediate 3 bytes, 3 cycles; pointer increment 1 cycle.
// - Code byte read adds accumulator to pointer or program counter, 3 cycles.
// - External data reads take 3-10 cycles, writes 4-11 cycles.
// - Push direct is 2 bytes, 4 cycles; pop direct 2 bytes, 3 cycles.
// - Two-bit bank select chooses one of four banks at 0x00-0x1F.
// - Pointer select bit 0 chooses which of two data pointers is used.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module cid_core #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   busy
);

  // ==========================================================================
  // Storage and decode
  localparam int IDX_W_L = cid_pkg::IDX_W;
  cid_pkg::cid_instr_s  instr_reg;
  cid_pkg::cid_dec_s    dec;
  cid_pkg::cid_state_e  state_reg;
  logic [15:0]          pc_reg;
  logic [15:0]          active_data_pointer_reg [2];
  logic                 ptr_sel_reg;
  logic [7:0]           status_word_reg;
  logic [7:0]           ram [256];
  logic [7:0]           stack_top;
  logic [3:0]           cnt_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic                 busy_reg;
  logic [IDX_W_L-1:0]   idx;
  logic                 access;
  logic                 wr_fire;
  logic                 exec_fire;
  logic [1:0]           bank;
  logic [7:0]           opa_addr;
  logic                 opa_sfr;
  logic                 opa_valid;
  logic [15:0]          next_pc;
  logic [15:0]          target;
  logic [7:0]           push_src;
  logic [31:0]          rd_data;
  logic                 rd_ok;
  logic                 sfr_wr;
  logic [7:0]           sfr_addr;
  logic [7:0]           sfr_data;


  assign idx       = paddr[IDX_W_L+1:2];
  assign access    = psel & penable;
  assign wr_fire   = access & pready_reg & pwrite & ~pslverr_reg;
  assign exec_fire = wr_fire & (idx == cid_pkg::IDX_EXEC);
  assign bank      = status_word_reg[cid_pkg::BANK_LSB +: 2];

  cid_decode u_decode (
    .opcode (instr_reg.opcode),
    .dec    (dec)
  );

  // ==========================================================================
  // Operand address and branch targets
  always_comb begin
    opa_addr  = 8'h00;
    opa_sfr   = 1'b0;
    opa_valid = 1'b1;
    case (dec.mode)
      cid_pkg::MODE_REG:      opa_addr = {3'b000, bank, instr_reg.opcode[2:0]};
      cid_pkg::MODE_DIRECT: begin
        opa_addr = instr_reg.op1;
        opa_sfr  = instr_reg.op1[cid_pkg::DIRECT_SFR_BIT];
      end
      cid_pkg::MODE_INDIRECT: opa_addr = ram[{3'b000, bank, 2'b00, instr_reg.opcode[0]}];
      default:                opa_valid = 1'b0;
    endcase
  end

  assign next_pc = pc_reg + {14'h0000, dec.len};

  always_comb begin
    case (dec.mode)
      cid_pkg::MODE_ADDR11: target = {next_pc[15:11], instr_reg.opcode[7:5], instr_reg.op1};
      cid_pkg::MODE_REL:    target = next_pc + {{8{instr_reg.op1[7]}}, instr_reg.op1};
      cid_pkg::MODE_ADDR16: target = {instr_reg.op1, instr_reg.op2};
      default:              target = 16'h0000;
    endcase
  end

  // Byte pushed: data RAM below 0x80, special function area above
  always_comb begin
    push_src = 8'h00;
    if (!instr_reg.op1[cid_pkg::DIRECT_SFR_BIT]) begin
      push_src = ram[instr_reg.op1];
    end else begin
      case (instr_reg.op1)
        cid_pkg::SFR_STACK_TOP:   push_src = stack_top;
        cid_pkg::SFR_PTR0_LO:     push_src = active_data_pointer_reg[0][7:0];
        cid_pkg::SFR_PTR0_HI:     push_src = active_data_pointer_reg[0][15:8];
        cid_pkg::SFR_PTR1_LO:     push_src = active_data_pointer_reg[1][7:0];
        cid_pkg::SFR_PTR1_HI:     push_src = active_data_pointer_reg[1][15:8];
        cid_pkg::SFR_PTR_SEL:     push_src = {7'h00, ptr_sel_reg};
        cid_pkg::SFR_STATUS_WORD: push_src = status_word_reg;
        default:                  push_src = 8'h00;
      endcase
    end
  end

  // Pop into a special function byte, else a software write to one
  always_comb begin
    sfr_wr   = 1'b0;
    sfr_addr = 8'h00;
    sfr_data = pwdata[7:0];
    if (exec_fire && instr_reg.opcode == cid_pkg::OPC_POP && instr_reg.op1[cid_pkg::DIRECT_SFR_BIT]) begin
      sfr_wr   = 1'b1;
      sfr_addr = instr_reg.op1;
      sfr_data = ram[stack_top];
    end else if (wr_fire && idx == cid_pkg::IDX_PTR_SEL) begin
      sfr_wr   = 1'b1;
      sfr_addr = cid_pkg::SFR_PTR_SEL;
    end else if (wr_fire && idx == cid_pkg::IDX_STATUS_WORD) begin
      sfr_wr   = 1'b1;
      sfr_addr = cid_pkg::SFR_STATUS_WORD;
    end
  end

  // ==========================================================================
  // Stack
  cid_stack u_stack (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (exec_fire && instr_reg.opcode == cid_pkg::OPC_PUSH),
    .pop       (exec_fire && instr_reg.opcode == cid_pkg::OPC_POP),
    .wr        ((wr_fire && idx == cid_pkg::IDX_STACK_TOP) || (sfr_wr && sfr_addr == cid_pkg::SFR_STACK_TOP)),
    .wdata     (sfr_wr ? sfr_data : pwdata[7:0]),
    .stack_top (stack_top)
  );

  always_ff @(posedge pclk) begin
    if (exec_fire && instr_reg.opcode == cid_pkg::OPC_PUSH) begin
      ram[stack_top + 8'h01] <= push_src;
    end else if (exec_fire && instr_reg.opcode == cid_pkg::OPC_POP && !instr_reg.op1[7]) begin
      ram[instr_reg.op1] <= ram[stack_top];
    end else if (wr_fire && idx[IDX_W_L-1:8] == cid_pkg::IDX_RAM_PAGE) begin
      ram[idx[7:0]] <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= '0;
      pc_reg    <= 16'h0000;
    end else if (wr_fire && idx == cid_pkg::IDX_INSTR) begin
      instr_reg <= pwdata[23:0];
    end else if (wr_fire && idx == cid_pkg::IDX_PC) begin
      pc_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_sel_reg     <= 1'b0;
      status_word_reg <= 8'h00;
    end else if (sfr_wr && sfr_addr == cid_pkg::SFR_PTR_SEL) begin
      ptr_sel_reg <= sfr_data[0];
    end else if (sfr_wr && sfr_addr == cid_pkg::SFR_STATUS_WORD) begin
      status_word_reg <= sfr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_data_pointer_reg[0] <= 16'h0000;
      active_data_pointer_reg[1] <= 16'h0000;
    end else if (exec_fire && instr_reg.opcode == cid_pkg::OPC_LOAD_PTR) begin
      active_data_pointer_reg[ptr_sel_reg] <= {instr_reg.op1, instr_reg.op2};
    end else if (exec_fire && instr_reg.opcode == cid_pkg::OPC_INC_PTR) begin
      active_data_pointer_reg[ptr_sel_reg] <= active_data_pointer_reg[ptr_sel_reg] + 16'h0001;
    end else if (wr_fire && idx == cid_pkg::IDX_DPTR0) begin
      active_data_pointer_reg[0] <= pwdata[15:0];
    end else if (wr_fire && idx == cid_pkg::IDX_DPTR1) begin
      active_data_pointer_reg[1] <= pwdata[15:0];
    end else if (sfr_wr && sfr_addr == cid_pkg::SFR_PTR0_LO) begin
      active_data_pointer_reg[0][7:0] <= sfr_data;
    end else if (sfr_wr && sfr_addr == cid_pkg::SFR_PTR0_HI) begin
      active_data_pointer_reg[0][15:8] <= sfr_data;
    end else if (sfr_wr && sfr_addr == cid_pkg::SFR_PTR1_LO) begin
      active_data_pointer_reg[1][7:0] <= sfr_data;
    end else if (sfr_wr && sfr_addr == cid_pkg::SFR_PTR1_HI) begin
      active_data_pointer_reg[1][15:8] <= sfr_data;
    end
  end

  // ==========================================================================
  // Sequencing: busy for the decoded least cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cid_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
      busy_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        cid_pkg::ST_IDLE: begin
          if (exec_fire) begin
            state_reg <= cid_pkg::ST_RUN;
            cnt_reg   <= dec.cyc_min;
            busy_reg  <= 1'b1;
          end
        end
        cid_pkg::ST_RUN: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            state_reg <= cid_pkg::ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // APB read mux and answer
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (idx[IDX_W_L-1:8] == cid_pkg::IDX_RAM_PAGE) begin
      rd_data[7:0] = ram[idx[7:0]];
    end else begin
      case (idx)
        cid_pkg::IDX_INSTR:  rd_data[23:0] = instr_reg;
        cid_pkg::IDX_PC:     rd_data[15:0] = pc_reg;
        cid_pkg::IDX_DECODE: begin
          rd_data[cid_pkg::DEC_LEN_LSB +: 2]  = dec.len;
          rd_data[cid_pkg::DEC_CMIN_LSB +: 4] = dec.cyc_min;
          rd_data[cid_pkg::DEC_CMAX_LSB +: 4] = dec.cyc_max;
          rd_data[cid_pkg::DEC_MODE_LSB +: 4] = dec.mode;
          rd_data[cid_pkg::DEC_KNOWN_BIT]     = dec.known;
          rd_data[cid_pkg::DEC_BUSY_BIT]      = busy_reg;
        end
        cid_pkg::IDX_OPADDR: begin
          rd_data[7:0]                       = opa_addr;
          rd_data[cid_pkg::OPA_SFR_BIT]      = opa_sfr;
          rd_data[cid_pkg::OPA_VALID_BIT]    = opa_valid;
        end
        cid_pkg::IDX_TARGET:      rd_data[15:0] = target;
        cid_pkg::IDX_EXEC:        rd_data = 32'h0000_0000;
        cid_pkg::IDX_DPTR0:       rd_data[15:0] = active_data_pointer_reg[0];
        cid_pkg::IDX_DPTR1:       rd_data[15:0] = active_data_pointer_reg[1];
        cid_pkg::IDX_STACK_TOP:   rd_data[7:0] = stack_top;
        cid_pkg::IDX_PTR_SEL:     rd_data[0] = ptr_sel_reg;
        cid_pkg::IDX_STATUS_WORD: rd_data[7:0] = status_word_reg;
        default:                  rd_ok = 1'b0;
      endcase
    end
  end

  // One wait state; refused exec (busy or unknown opcode) answers with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg &
                     (~rd_ok | (pwrite & (idx == cid_pkg::IDX_EXEC) & (busy_reg | ~dec.known)));
      prdata_reg  <= (access & ~pready_reg & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign busy    = busy_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_push_start;
    exec_fire && instr_reg.opcode == cid_pkg::OPC_PUSH && state_reg == cid_pkg::ST_IDLE;
  endsequence

  sequence s_run_four;
    busy_reg [*4] ##1 !busy_reg;
  endsequence

  a_push_order: assert property (s_push_start |=> stack_top == $past(stack_top) + 8'h01
                                 && ram[stack_top] == $past(push_src))
    else $error("push did not increment then write");
  a_push_timing: assert property (s_push_start |=> s_run_four)
    else $error("push busy length wrong");
  a_run_length: assert property (exec_fire && !busy_reg |=> busy_reg [*1] ##0 cnt_reg == $past(dec.cyc_min))
    else $error("run count not loaded from decode");
  a_run_ends: assert property (exec_fire && !busy_reg |-> ##[1:12] !busy_reg)
    else $error("run did not end");
  a_reg_select: assert property (dec.mode == cid_pkg::MODE_REG |->
                                 opa_addr == {3'b000, status_word_reg[4:3], instr_reg.opcode[2:0]})
    else $error("working register address wrong");
  a_direct_area: assert property (dec.mode == cid_pkg::MODE_DIRECT |-> opa_sfr == (instr_reg.op1 >= 8'h80))
    else $error("direct area split wrong");
  a_abs_page: assert property (dec.mode == cid_pkg::MODE_ADDR11 |->
                               target[15:11] == next_pc[15:11] && target[10:0] == {instr_reg.opcode[7:5], instr_reg.op1})
    else $error("page target wrong");
  a_rel_target: assert property (dec.mode == cid_pkg::MODE_REL |->
                                 target == 16'(pc_reg + 16'h0002 + {{8{instr_reg.op1[7]}}, instr_reg.op1}))
    else $error("relative target wrong");
  a_and_direct: assert property (instr_reg.opcode == 8'h53 |-> dec.len == 2'd3 && dec.cyc_min == 4'd4)
    else $error("and immediate to direct timing wrong");
  a_ptr_load: assert property (exec_fire && instr_reg.opcode == cid_pkg::OPC_LOAD_PTR |=>
                               active_data_pointer_reg[$past(ptr_sel_reg)] == {$past(instr_reg.op1), $past(instr_reg.op2)})
    else $error("pointer load wrong");

endmodule : cid_core

// >>> cid_pkg.sv
// Package of constants and types for the instruction decode block
package cid_pkg;

  // ==========================================================================
  // Register indexes (byte address is four times the index)
  localparam int         IDX_W           = 10;
  localparam logic [9:0] IDX_INSTR       = 10'h000;
  localparam logic [9:0] IDX_PC          = 10'h001;
  localparam logic [9:0] IDX_DECODE      = 10'h002;
  localparam logic [9:0] IDX_OPADDR      = 10'h003;
  localparam logic [9:0] IDX_TARGET      = 10'h004;
  localparam logic [9:0] IDX_EXEC        = 10'h005;
  localparam logic [9:0] IDX_DPTR0       = 10'h006;
  localparam logic [9:0] IDX_DPTR1       = 10'h007;
  localparam logic [9:0] IDX_STACK_TOP   = 10'h081;
  localparam logic [9:0] IDX_PTR_SEL     = 10'h092;
  localparam logic [9:0] IDX_STATUS_WORD = 10'h0d0;
  localparam logic [1:0] IDX_RAM_PAGE    = 2'h1;

  // ==========================================================================
  // Field positions
  localparam int DEC_LEN_LSB      = 0;
  localparam int DEC_CMIN_LSB     = 4;
  localparam int DEC_CMAX_LSB     = 8;
  localparam int DEC_MODE_LSB     = 12;
  localparam int DEC_KNOWN_BIT    = 16;
  localparam int DEC_BUSY_BIT     = 17;
  localparam int OPA_SFR_BIT      = 8;
  localparam int OPA_VALID_BIT    = 9;
  localparam int BANK_LSB         = 3;
  localparam int DIRECT_SFR_BIT   = 7;

  // ==========================================================================
  // Reset values, special function addresses and executed opcodes
  localparam logic [7:0] STACK_TOP_RESET = 8'h07;
  localparam logic [7:0] SFR_STACK_TOP   = 8'h81;
  localparam logic [7:0] SFR_PTR0_LO     = 8'h82;
  localparam logic [7:0] SFR_PTR0_HI     = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO     = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI     = 8'h85;
  localparam logic [7:0] SFR_PTR_SEL     = 8'h92;
  localparam logic [7:0] SFR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] OPC_LOAD_PTR    = 8'h90;
  localparam logic [7:0] OPC_INC_PTR     = 8'ha3;
  localparam logic [7:0] OPC_PUSH        = 8'hc0;
  localparam logic [7:0] OPC_POP         = 8'hd0;

  typedef enum logic [3:0] {
    MODE_NONE, MODE_REG, MODE_DIRECT, MODE_INDIRECT, MODE_IMM,
    MODE_ADDR11, MODE_REL, MODE_ADDR16, MODE_PTR, MODE_EXT
  } cid_mode_e;

  typedef struct packed {
    logic      known;
    logic [1:0] len;
    logic [3:0] cyc_min;
    logic [3:0] cyc_max;
    cid_mode_e  mode;
  } cid_dec_s;

  typedef struct packed {
    logic [7:0] op2;
    logic [7:0] op1;
    logic [7:0] opcode;
  } cid_instr_s;

  typedef enum logic {ST_IDLE, ST_RUN} cid_state_e;

endpackage : cid_pkg

// >>> cid_decode.sv
// Opcode table: length, cycle range and operand mode
`timescale 1ns/1ps
module cid_decode (
  input  wire logic [7:0]        opcode,
  output cid_pkg::cid_dec_s      dec
);

  function automatic cid_pkg::cid_dec_s ent(input logic [1:0] l, input logic [3:0] cmin,
                                            input logic [3:0] cmax, input cid_pkg::cid_mode_e m);
    cid_pkg::cid_dec_s r;
    r.known   = 1'b1;
    r.len     = l;
    r.cyc_min = cmin;
    r.cyc_max = cmax;
    r.mode    = m;
    return r;
  endfunction : ent

  always_comb begin
    dec = '0;
    if (opcode[3]) begin
      case (opcode[7:4])
        4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6, 4'he: dec = ent(2'd1, 4'd1, 4'd1, cid_pkg::MODE_REG);
        4'h0, 4'h1, 4'hc: dec = ent(2'd1, 4'd2, 4'd2, cid_pkg::MODE_REG);
        4'hf:             dec = ent(2'd1, 4'd2, 4'd2, cid_pkg::MODE_REG);
        4'h7:             dec = ent(2'd2, 4'd2, 4'd2, cid_pkg::MODE_REG);
        4'ha:             dec = ent(2'd2, 4'd4, 4'd4, cid_pkg::MODE_REG);
        4'h8:             dec = ent(2'd2, 4'd3, 4'd3, cid_pkg::MODE_REG);
        default:          dec = '0;
      endcase
    end else if (opcode[4:0] == 5'b00001) begin
      dec = ent(2'd2, 4'd3, 4'd3, cid_pkg::MODE_ADDR11);
    end else if (opcode[4:0] == 5'b10001) begin
      dec = ent(2'd2, 4'd6, 4'd6, cid_pkg::MODE_ADDR11);
    end else begin
      casez (opcode)
        8'h24, 8'h34, 8'h94, 8'h44, 8'h54, 8'h64, 8'h74:
          dec = ent(2'd2, 4'd2, 4'd2, cid_pkg::MODE_IMM);
        8'h25, 8'h35, 8'h95, 8'h45, 8'h55, 8'h65, 8'he5:
          dec = ent(2'd2, 4'd2, 4'd2, cid_pkg::MODE_DIRECT);
        8'b0010_011?, 8'b0011_011?, 8'b1001_011?, 8'b0100_011?, 8'b0101_011?, 8'b0110_011?, 8'b1110_011?:
          dec = ent(2'd1, 4'd2, 4'd2, cid_pkg::MODE_INDIRECT);
        8'h42, 8'h52, 8'h62: dec = ent(2'd2, 4'd3, 4'd3, cid_pkg::MODE_DIRECT);
        8'h43, 8'h53, 8'h63: dec = ent(2'd3, 4'd4, 4'd4, cid_pkg::MODE_DIRECT);
        8'h03, 8'h13, 8'h23, 8'h33, 8'hc4, 8'he4, 8'hf4, 8'h04, 8'h14, 8'hd4:
          dec = ent(2'd1, 4'd1, 4'd1, cid_pkg::MODE_NONE);
        8'h05, 8'h15, 8'hf5, 8'hc5, 8'hd0: dec = ent(2'd2, 4'd3, 4'd3, cid_pkg::MODE_DIRECT);
        8'b0000_011?, 8'b0001_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?:
          dec = ent(2'd1, 4'd3, 4'd3, cid_pkg::MODE_INDIRECT);
        8'ha4, 8'h84: dec = ent(2'd1, 4'd5, 4'd5, cid_pkg::MODE_NONE);
        8'ha3:        dec = ent(2'd1, 4'd1, 4'd1, cid_pkg::MODE_PTR);
        8'h90:        dec = ent(2'd3, 4'd3, 4'd3, cid_pkg::MODE_PTR);
        8'h93:        dec = ent(2'd1, 4'd3, 4'd3, cid_pkg::MODE_PTR);
        8'h83:        dec = ent(2'd1, 4'd3, 4'd3, cid_pkg::MODE_NONE);
        8'h85, 8'hc0: dec = ent(opcode[6] ? 2'd2 : 2'd3, 4'd4, 4'd4, cid_pkg::MODE_DIRECT);
        8'h75:        dec = ent(2'd3, 4'd3, 4'd3, cid_pkg::MODE_DIRECT);
        8'b1000_011?: dec = ent(2'd2, 4'd4, 4'd4, cid_pkg::MODE_INDIRECT);
        8'b1010_011?: dec = ent(2'd2, 4'd5, 4'd5, cid_pkg::MODE_INDIRECT);
        8'b0111_011?: dec = ent(2'd2, 4'd3, 4'd3, cid_pkg::MODE_INDIRECT);
        8'he0, 8'b1110_001?: dec = ent(2'd1, 4'd3, 4'd10, cid_pkg::MODE_EXT);
        8'hf0, 8'b1111_001?: dec = ent(2'd1, 4'd4, 4'd11, cid_pkg::MODE_EXT);
        8'h02:        dec = ent(2'd3, 4'd4, 4'd4, cid_pkg::MODE_ADDR16);
        8'h12:        dec = ent(2'd3, 4'd6, 4'd6, cid_pkg::MODE_ADDR16);
        8'h80:        dec = ent(2'd2, 4'd3, 4'd3, cid_pkg::MODE_REL);
        default:      dec = '0;
      endcase
    end
  end

endmodule : cid_decode

// >>> cid_stack.sv
// Stack top pointer with push, pop and software write
`timescale 1ns/1ps
module cid_stack (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] stack_top
);

  logic [7:0] stack_top_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_top_reg <= cid_pkg::STACK_TOP_RESET;
    end else if (wr) begin
      stack_top_reg <= wdata;
    end else if (push) begin
      stack_top_reg <= stack_top_reg + 8'h01;
    end else if (pop) begin
      stack_top_reg <= stack_top_reg - 8'h01;
    end
  end

  assign stack_top = stack_top_reg;

endmodule : cid_stack

// >>> tb_cpu_instruction_decode.sv
// Self-checking bench for the instruction decode block over APB
`timescale 1ns/1ps
module tb_cpu_instruction_decode;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] eq[$], mq[$];
  int          mismatches, n_checks;
  logic [7:0]  d;
  // Opcode, length, least cycles, most cycles
  logic [19:0] tbl [41] = '{20'h28111, 20'h25222, 20'h26122, 20'h24222, 20'h3f111, 20'h35222, 20'h34222,
    20'h94222, 20'h9f111, 20'h96122, 20'h52233, 20'h53344, 20'h42233, 20'h43344, 20'h4a111,
    20'h62233, 20'h6f111, 20'h65222, 20'h23111, 20'h33111, 20'h03111, 20'h13111, 20'hc4111,
    20'he4111, 20'hf4111, 20'he8111, 20'he5222, 20'h74222, 20'hf8122, 20'h78222, 20'ha8244,
    20'h85344, 20'h75333, 20'h90333, 20'ha3111, 20'h93133, 20'h83133, 20'he213a, 20'hf014b,
    20'hc0244, 20'hd0233};

  cid_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========================================================================
  // Checking
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1) begin
      chk({pslverr, prdata} & mq.pop_front(), eq.pop_front());
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #(100 * 8000);
    mismatches++;
    wrap_up();
  end

  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] v, input logic [32:0] e,
                     input logic [32:0] m);
    int n;
    eq.push_back(e);
    mq.push_back(m);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] i, input logic [31:0] v);
    apb(1'b1, i, v, 33'h0, 33'h1_0000_0000);
  endtask : wr

  task automatic rdm(input logic [9:0] i, input logic [31:0] e, input logic [32:0] m);
    apb(1'b0, i, 32'h0, {1'b0, e}, m);
  endtask : rdm

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    rdm(i, e, 33'h1_ffff_ffff);
  endtask : rd

  task automatic exec(input logic [23:0] ins, input int c);
    int n;
    wr(cid_pkg::IDX_INSTR, {8'h00, ins});
    wr(cid_pkg::IDX_EXEC, 32'h0);
    n = 0;
    @(negedge pclk);
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    chk(33'(n), 33'(c));
  endtask : exec

  task automatic opchk(input logic [15:0] pc, input logic [23:0] ins, input logic [9:0] i, input logic [15:0] e);
    wr(cid_pkg::IDX_PC, {16'h0, pc});
    wr(cid_pkg::IDX_INSTR, {8'h00, ins});
    rdm(i, {16'h0, e}, (i == cid_pkg::IDX_TARGET) ? 33'h1_0000_ffff : 33'h1_0000_03ff);
  endtask : opchk

  // ==========================================================================
  // Tests
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(32'h7c45));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(cid_pkg::IDX_STACK_TOP, 32'h7);
    rd(cid_pkg::IDX_PTR_SEL, 32'h0);
    foreach (tbl[k]) begin
      wr(cid_pkg::IDX_INSTR, {24'h0, tbl[k][19:12]});
      rdm(cid_pkg::IDX_DECODE, {15'h0, 1'b1, 4'h0, tbl[k][3:0], tbl[k][7:4], 2'b0, tbl[k][9:8]}, 33'h1_0001_0ff3);
    end
    wr(cid_pkg::IDX_INSTR, 32'ha5);
    rd(cid_pkg::IDX_DECODE, 32'h0);
    $display("test decode table done");
    wr(cid_pkg::IDX_STATUS_WORD, 32'h10);
    wr({cid_pkg::IDX_RAM_PAGE, 8'h11}, 32'hc5);
    opchk(16'h0, 24'h008525, cid_pkg::IDX_OPADDR, 16'h385);
    opchk(16'h0, 24'h007f25, cid_pkg::IDX_OPADDR, 16'h27f);
    opchk(16'h0, 24'h000027, cid_pkg::IDX_OPADDR, 16'h2c5);
    opchk(16'h0, 24'h00002d, cid_pkg::IDX_OPADDR, 16'h215);
    opchk(16'h37fe, 24'h0045b1, cid_pkg::IDX_TARGET, 16'h3d45);
    opchk(16'h1000, 24'h00fe80, cid_pkg::IDX_TARGET, 16'h1000);
    opchk(16'h2000, 24'h007f80, cid_pkg::IDX_TARGET, 16'h2081);
    opchk(16'h37fe, 24'hcdab12, cid_pkg::IDX_TARGET, 16'habcd);
    $display("test operands done");
    d = 8'($urandom);
    wr({cid_pkg::IDX_RAM_PAGE, 8'h33}, {24'h0, d});
    exec(24'h0033c0, 4);
    rd(cid_pkg::IDX_STACK_TOP, 32'h8);
    rd({cid_pkg::IDX_RAM_PAGE, 8'h08}, {24'h0, d});
    exec(24'h0040d0, 3);
    rd({cid_pkg::IDX_RAM_PAGE, 8'h40}, {24'h0, d});
    rd(cid_pkg::IDX_STACK_TOP, 32'h7);
    $display("test stack done");
    wr(cid_pkg::IDX_PTR_SEL, 32'h1);
    exec(24'h341290, 3);
    rd(cid_pkg::IDX_DPTR1, 32'h1234);
    rd(cid_pkg::IDX_DPTR0, 32'h0);
    exec(24'h0000a3, 1);
    rd(cid_pkg::IDX_DPTR1, 32'h1235);
    wr(cid_pkg::IDX_INSTR, 32'ha5);
    apb(1'b1, cid_pkg::IDX_EXEC, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b0, 10'h3ff, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
    $display("test pointers and refusals done");
    wrap_up();
  end
endmodule : tb_cpu_instruction_decode
